// *** hw/fpp_flash_ctrl.sv ***
// flash sequencer with protection and nonvolatile commit
`timescale 1ns/10ps
// Summary of operation
// - page erase sets whole 1-KB page to ones
// - programming only clears bits already one
// - protection per 2-KB region of page pairs
// - timing ticks from reload value, MHz minus one
// - reload resets to default for top clock
// - program-enable zero refuses program and erase
// - read-enable zero allows only instruction fetches
// - refused change suppressed, fault raised if masked
// - blocked data read returns all zeros
// - factory protection bits all one when implemented
// - volatile protection changes revert at reset
// - mass erase clears array, bit busy meanwhile
// - nonvolatile words untouched by any erase
// - commit saves address-selected register, bit busy
// - debug word commits from data register
// - committed bits only move from one to zero
// - user and debug words commit only once
// - commit register chosen by fixed address values
// - operation bit reads one until completion
module fpp_flash_ctrl #(
  parameter int REGIONS       = fpp_pkg::REGIONS_DFLT,
  parameter int PAGE_ERASE_US = fpp_pkg::PAGE_ERASE_US,
  parameter int MASS_ERASE_US = fpp_pkg::MASS_ERASE_US
) (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     nv_init_i,
  input  wire fpp_pkg::fpp_wr_type      addr_wr_i,
  input  wire fpp_pkg::fpp_wr_type      data_wr_i,
  input  wire fpp_pkg::fpp_wr_type      ctrl_wr_i,
  input  wire fpp_pkg::fpp_wr_type      usec_wr_i,
  input  wire fpp_pkg::fpp_sel_wr_type  prot_wr_i,
  input  wire fpp_pkg::fpp_sel_wr_type  user_wr_i,
  input  wire logic                     access_fault_mask_i,
  input  wire fpp_pkg::fpp_rd_req_type  rd_req_i,
  input  wire logic [31:0]              arr_rdata_i,
  output logic [31:0]                   addr_rdata_o,
  output logic [31:0]                   data_rdata_o,
  output logic [31:0]                   ctrl_rdata_o,
  output logic [7:0]                    usec_rdata_o,
  output fpp_pkg::fpp_bank_type         read_enable_bits_o,
  output fpp_pkg::fpp_bank_type         program_enable_bits_o,
  output logic [1:0][31:0]              user_words_o,
  output logic [31:0]                   debug_config_word_o,
  output logic                          busy_o,
  output logic                          prog_fault_o,
  output logic                          access_fault_o,
  output logic                          read_fault_o,
  output logic                          rd_ready_o,
  output logic                          rd_valid_o,
  output logic [31:0]                   rd_data_o,
  output fpp_pkg::fpp_arr_req_type      arr_req_o
);
  import fpp_pkg::*;

  localparam fpp_bank_type IMPL = fpp_impl(REGIONS);

  typedef struct packed {
    fpp_state_type    st;
    logic [31:0]      addr;
    logic [31:0]      data;
    logic [31:0]      old;
    logic [7:0]       reload;
    logic [OPS-1:0]   op;
    fpp_bank_type     re;
    fpp_bank_type     pe;
    logic [1:0][31:0] user;
    fpp_bank_type     nv_re;
    fpp_bank_type     nv_pe;
    logic [1:0][31:0] nv_user;
    logic [31:0]      nv_dbg;
    logic             rd_p1;
    logic             rd_blk1;
    logic             rd_valid;
    logic [31:0]      rd_data;
    logic             tstart;
    logic [US_W-1:0]  dur;
    logic             pfault;
    logic             afault;
    logic             rfault;
  } fpp_main_type;

  fpp_main_type s_r;
  fpp_main_type s_nxt;
  logic         rd_take;
  logic         rd_re_ok;
  logic         op_pe_ok;
  logic         key_ok;
  logic         all_pe_ok;
  logic         t_done;

  fpp_prot_check u_prot (
    .re_i       (s_r.re),
    .pe_i       (s_r.pe),
    .rd_addr_i  (rd_req_i.addr),
    .op_addr_i  (s_r.addr),
    .rd_re_ok_o (rd_re_ok),
    .op_pe_ok_o (op_pe_ok)
  );

  fpp_us_timer u_tmr (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .reload_i  (s_r.reload),
    .start_i   (s_r.tstart),
    .dur_i     (s_r.dur),
    .done_o    (t_done)
  );

  // array is single-ported, so reads wait while it programs or erases
  assign rd_ready_o = (s_r.st == ST_IDLE) || (s_r.st == ST_COMMIT);
  assign rd_take = rd_req_i.req && rd_ready_o;
  assign key_ok = ctrl_wr_i.we &&
                  (ctrl_wr_i.data[KEY_LSB +: 16] == FLASH_KEY);
  assign all_pe_ok = &(s_r.pe | ~IMPL);

  always_comb begin
    logic cm_hit;
    cm_hit = 1'b0;
    s_nxt = s_r;
    s_nxt.tstart = 1'b0;
    s_nxt.pfault = 1'b0;
    s_nxt.afault = 1'b0;
    s_nxt.rfault = 1'b0;
    s_nxt.rd_valid = s_r.rd_p1;
    s_nxt.rd_p1 = rd_take;
    s_nxt.rd_blk1 = rd_take && !rd_req_i.fetch && !rd_re_ok;
    if (s_r.rd_p1) begin
      s_nxt.rd_data = s_r.rd_blk1 ? 32'h00000000 : arr_rdata_i;
      s_nxt.rfault = s_r.rd_blk1;
    end
    if (addr_wr_i.we) begin
      s_nxt.addr = addr_wr_i.data;
    end
    if (data_wr_i.we) begin
      s_nxt.data = data_wr_i.data;
    end
    if (usec_wr_i.we) begin
      s_nxt.reload = usec_wr_i.data[7:0];
    end
    // volatile copies can only drop below what is committed
    if (prot_wr_i.we) begin
      if (prot_wr_i.sel[2]) begin
        s_nxt.pe[prot_wr_i.sel[1:0]] =
          prot_wr_i.data & s_r.nv_pe[prot_wr_i.sel[1:0]];
      end else begin
        s_nxt.re[prot_wr_i.sel[1:0]] =
          prot_wr_i.data & s_r.nv_re[prot_wr_i.sel[1:0]];
      end
    end
    if (user_wr_i.we) begin
      s_nxt.user[user_wr_i.sel[0]] =
        user_wr_i.data & s_r.nv_user[user_wr_i.sel[0]];
    end
    case (s_r.st)
      ST_IDLE: begin
        // control writes during a busy phase are dropped
        if (key_ok) begin
          if (ctrl_wr_i.data[OP_WRITE]) begin
            if (op_pe_ok) begin
              s_nxt.st = ST_RDOLD;
              s_nxt.op[OP_WRITE] = 1'b1;
            end else begin
              s_nxt.pfault = 1'b1;
              s_nxt.afault = access_fault_mask_i;
            end
          end else if (ctrl_wr_i.data[OP_ERASE]) begin
            if (op_pe_ok) begin
              s_nxt.st = ST_ERASE;
              s_nxt.op[OP_ERASE] = 1'b1;
              s_nxt.tstart = 1'b1;
              s_nxt.dur = US_W'(PAGE_ERASE_US);
            end else begin
              s_nxt.pfault = 1'b1;
              s_nxt.afault = access_fault_mask_i;
            end
          end else if (ctrl_wr_i.data[OP_MASS]) begin
            // any locked region blocks the whole mass erase
            if (all_pe_ok) begin
              s_nxt.st = ST_MASS;
              s_nxt.op[OP_MASS] = 1'b1;
              s_nxt.tstart = 1'b1;
              s_nxt.dur = US_W'(MASS_ERASE_US);
            end else begin
              s_nxt.pfault = 1'b1;
              s_nxt.afault = access_fault_mask_i;
            end
          end else if (ctrl_wr_i.data[OP_COMMIT]) begin
            for (int i = 0; i < BANKS; i++) begin
              if (s_r.addr == CA_RE[i]) begin
                cm_hit = 1'b1;
                s_nxt.nv_re[i] = s_r.nv_re[i] & s_r.re[i];
              end
              if (s_r.addr == CA_PE[i]) begin
                cm_hit = 1'b1;
                s_nxt.nv_pe[i] = s_r.nv_pe[i] & s_r.pe[i];
              end
            end
            for (int i = 0; i < 2; i++) begin
              if (s_r.addr == CA_USER[i] &&
                  s_r.nv_user[i][NW_BIT]) begin
                cm_hit = 1'b1;
                s_nxt.nv_user[i] =
                  s_r.nv_user[i] & s_r.user[i] & ~NW_MASK;
              end
            end
            if (s_r.addr == CA_DBG && s_r.nv_dbg[NW_BIT]) begin
              cm_hit = 1'b1;
              s_nxt.nv_dbg = s_r.nv_dbg & s_r.data & ~NW_MASK;
            end
            if (cm_hit) begin
              s_nxt.st = ST_COMMIT;
              s_nxt.op[OP_COMMIT] = 1'b1;
              s_nxt.tstart = 1'b1;
              s_nxt.dur = US_W'(COMMIT_US);
            end
          end
        end
      end
      ST_RDOLD: begin
        s_nxt.st = ST_CAPT;
      end
      ST_CAPT: begin
        s_nxt.old = arr_rdata_i;
        s_nxt.st = ST_PROG;
        s_nxt.tstart = 1'b1;
        s_nxt.dur = US_W'(PROG_US);
      end
      ST_PROG, ST_ERASE, ST_MASS, ST_COMMIT: begin
        if (t_done) begin
          s_nxt.st = ST_IDLE;
          s_nxt.op = '0;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (sys_rst_i) begin
      s_nxt = '0;
      s_nxt.st = ST_IDLE;
      s_nxt.reload = RELOAD_DFLT;
      s_nxt.nv_re = s_r.nv_re;
      s_nxt.nv_pe = s_r.nv_pe;
      s_nxt.nv_user = s_r.nv_user;
      s_nxt.nv_dbg = s_r.nv_dbg;
      if (nv_init_i) begin
        s_nxt.nv_re = IMPL;
        s_nxt.nv_pe = IMPL;
        s_nxt.nv_user = {USER_FACTORY, USER_FACTORY};
        s_nxt.nv_dbg = DBG_FACTORY;
      end
      s_nxt.re = s_nxt.nv_re;
      s_nxt.pe = s_nxt.nv_pe;
      s_nxt.user = s_nxt.nv_user;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
  end

  // nonvolatile words live here, never on the array erase path
  always_comb begin
    arr_req_o = '0;
    arr_req_o.rd = rd_take || (s_r.st == ST_RDOLD);
    arr_req_o.prog = (s_r.st == ST_PROG);
    arr_req_o.erase = (s_r.st == ST_ERASE);
    arr_req_o.mass = (s_r.st == ST_MASS);
    arr_req_o.addr = {s_r.addr[31:WORD_LSB], WORD_LSB'(0)};
    arr_req_o.wdata = s_r.old & s_r.data;
    if (rd_take) begin
      arr_req_o.addr = {rd_req_i.addr[31:WORD_LSB], WORD_LSB'(0)};
    end
    if (s_r.st == ST_ERASE) begin
      arr_req_o.addr = {s_r.addr[31:PAGE_LSB], PAGE_LSB'(0)};
      arr_req_o.wdata = '1;
    end
    if (s_r.st == ST_MASS) begin
      arr_req_o.wdata = '1;
    end
  end

  assign addr_rdata_o = s_r.addr;
  assign data_rdata_o = s_r.data;
  assign ctrl_rdata_o = 32'(s_r.op);
  assign usec_rdata_o = s_r.reload;
  assign read_enable_bits_o = s_r.re;
  assign program_enable_bits_o = s_r.pe;
  assign user_words_o = s_r.user;
  assign debug_config_word_o = s_r.nv_dbg;
  assign busy_o = (s_r.st != ST_IDLE);
  assign prog_fault_o = s_r.pfault;
  assign access_fault_o = s_r.afault;
  assign read_fault_o = s_r.rfault;
  assign rd_valid_o = s_r.rd_valid;
  assign rd_data_o = s_r.rd_data;

  a_erase_ones: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    arr_req_o.erase |-> (arr_req_o.wdata == '1 &&
                         arr_req_o.addr[PAGE_LSB-1:0] == '0))
    else $error("page erase not all ones or not page aligned");

  a_prog_clears: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    arr_req_o.prog |-> ((arr_req_o.wdata & ~s_r.old) == '0))
    else $error("program would set a zero bit");

  a_pe_refuse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_r.st == ST_IDLE && key_ok && ctrl_wr_i.data[OP_WRITE] && !op_pe_ok)
    |=> (s_r.st == ST_IDLE && prog_fault_o) [*1] ##1 (s_r.st == ST_IDLE))
    else $error("program of protected region not refused");

  a_fault_mask: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    prog_fault_o |-> (access_fault_o == $past(access_fault_mask_i)))
    else $error("access fault not gated by its mask");

  a_read_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    read_fault_o |-> (rd_valid_o && rd_data_o == 32'h00000000))
    else $error("blocked read returned data");

  a_fetch_pass: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (rd_take && rd_req_i.fetch) |-> ##2 (rd_valid_o && !read_fault_o))
    else $error("instruction fetch was blocked");

  a_nv_down: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !nv_init_i |=> (((s_r.nv_pe & ~$past(s_r.nv_pe)) == '0) &&
                    ((s_r.nv_re & ~$past(s_r.nv_re)) == '0) &&
                    ((s_r.nv_user & ~$past(s_r.nv_user)) == '0) &&
                    ((s_r.nv_dbg & ~$past(s_r.nv_dbg)) == '0)))
    else $error("committed bit returned to one");

  a_commit_once: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_r.st == ST_IDLE && key_ok && ctrl_wr_i.data[OP_COMMIT] &&
     ctrl_wr_i.data[OP_MASS:0] == '0 && s_r.addr == CA_USER[0] &&
     !s_r.nv_user[0][NW_BIT])
    |=> (s_r.st == ST_IDLE && $stable(s_r.nv_user[0])))
    else $error("user word committed twice");

  a_busy_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (s_r.st == ST_IDLE) == (ctrl_rdata_o[OPS-1:0] == '0))
    else $error("operation bit disagrees with progress");

  a_bad_key: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (ctrl_wr_i.we && ctrl_wr_i.data[KEY_LSB +: 16] != FLASH_KEY &&
     s_r.st == ST_IDLE) |=> (s_r.st == ST_IDLE && !prog_fault_o))
    else $error("write with wrong key had an effect");

  a_reload_dflt: assert property (@(posedge mclk_i)
    ($past(sys_rst_i) && !sys_rst_i) |-> (usec_rdata_o == RELOAD_DFLT))
    else $error("reload value wrong after reset");

endmodule

// *** hw/fpp_pkg.sv ***
// constants, types and helpers shared by the flash program/protect controller
package fpp_pkg;

  localparam int CLK_MHZ = 250;
  localparam logic [7:0] RELOAD_DFLT = 8'(CLK_MHZ - 1);

  localparam logic [15:0] FLASH_KEY = 16'ha442;
  localparam int KEY_LSB    = 16;
  localparam int OPS        = 4;
  localparam int OP_WRITE   = 0;
  localparam int OP_ERASE   = 1;
  localparam int OP_MASS    = 2;
  localparam int OP_COMMIT  = 3;

  localparam int WORD_LSB   = 2;
  localparam int PAGE_LSB   = 10;
  localparam int REGION_LSB = 11;
  localparam int REGION_W   = 7;
  localparam int BANKS      = 4;
  localparam int BANK_W     = 32;
  localparam int REGIONS_DFLT = 48;
  localparam int NW_BIT     = 31;
  localparam logic [31:0] NW_MASK      = 32'h80000000;
  localparam logic [31:0] USER_FACTORY = 32'h9fffffff;
  localparam logic [31:0] DBG_FACTORY  = 32'hfffffffe;

  localparam logic [BANKS-1:0][31:0] CA_RE =
    {32'h00000008, 32'h00000004, 32'h00000002, 32'h00000000};
  localparam logic [BANKS-1:0][31:0] CA_PE =
    {32'h00000007, 32'h00000005, 32'h00000003, 32'h00000001};
  localparam logic [1:0][31:0] CA_USER = {32'h80000001, 32'h80000000};
  localparam logic [31:0] CA_DBG = 32'h75100000;

  localparam int US_W          = 18;
  localparam int PROG_US       = 50;
  localparam int PAGE_ERASE_US = 25000;
  localparam int MASS_ERASE_US = 250000;
  localparam int COMMIT_US     = 50;

  typedef logic [BANKS-1:0][BANK_W-1:0] fpp_bank_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RDOLD  = 3'h1,
    ST_CAPT   = 3'h3,
    ST_PROG   = 3'h2,
    ST_ERASE  = 3'h6,
    ST_MASS   = 3'h7,
    ST_COMMIT = 3'h5
  } fpp_state_type;

  typedef struct packed {
    logic        we;
    logic [31:0] data;
  } fpp_wr_type;

  typedef struct packed {
    logic        we;
    logic [2:0]  sel;
    logic [31:0] data;
  } fpp_sel_wr_type;

  typedef struct packed {
    logic        req;
    logic        fetch;
    logic [31:0] addr;
  } fpp_rd_req_type;

  typedef struct packed {
    logic        rd;
    logic        prog;
    logic        erase;
    logic        mass;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fpp_arr_req_type;

  typedef struct packed {
    logic [7:0]      presc;
    logic [US_W-1:0] remain;
    logic            run;
    logic            done;
  } fpp_tmr_type;

  function automatic logic [REGION_W-1:0] fpp_region(input logic [31:0] a);
    return a[REGION_LSB +: REGION_W];
  endfunction

  function automatic fpp_bank_type fpp_impl(input int regions);
    fpp_bank_type m;
    m = '0;
    for (int i = 0; i < BANKS * BANK_W; i++) begin
      if (i < regions) begin
        m[i / BANK_W][i % BANK_W] = 1'b1;
      end
    end
    return m;
  endfunction

endpackage

// *** hw/fpp_us_timer.sv ***
// microsecond prescaler and duration counter
`timescale 1ns/10ps
module fpp_us_timer (
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [7:0]              reload_i,
  input  wire logic                    start_i,
  input  wire logic [fpp_pkg::US_W-1:0] dur_i,
  output logic                         done_o
);
  import fpp_pkg::*;

  fpp_tmr_type s_r;
  fpp_tmr_type s_nxt;
  logic        tick;
  logic [7:0]  gap_r;
  logic        seen_r;

  // one tick every reload+1 cycles, i.e. one microsecond
  assign tick = s_r.run && (s_r.presc == 8'h00);

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start_i) begin
      s_nxt.presc = reload_i;
      s_nxt.remain = dur_i;
      s_nxt.run = 1'b1;
    end else if (tick) begin
      s_nxt.presc = reload_i;
      if (s_r.remain <= US_W'(1)) begin
        s_nxt.run = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.remain = s_r.remain - US_W'(1);
      end
    end else if (s_r.run) begin
      s_nxt.presc = s_r.presc - 8'h01;
    end
    if (sys_rst_i) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_r <= s_nxt;
  end

  assign done_o = s_r.done;

  // cycle gap between ticks, watched only by the check below
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || start_i || !s_r.run) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (tick) begin
      gap_r <= 8'h00;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 8'h01;
    end
  end

  a_tick_gap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (tick && seen_r && $stable(reload_i)) |-> (gap_r == reload_i))
    else $error("tick spacing differs from reload value");

endmodule

// *** hw/fpp_prot_check.sv ***
// region lookup of read-enable and program-enable bits
`timescale 1ns/10ps
module fpp_prot_check (
  input  wire fpp_pkg::fpp_bank_type re_i,
  input  wire fpp_pkg::fpp_bank_type pe_i,
  input  wire logic [31:0]           rd_addr_i,
  input  wire logic [31:0]           op_addr_i,
  output logic                       rd_re_ok_o,
  output logic                       op_pe_ok_o
);
  import fpp_pkg::*;

  logic [REGION_W-1:0] rd_reg;
  logic [REGION_W-1:0] op_reg;

  // two 1-KB pages share one region, so the page bit is dropped
  assign rd_reg = fpp_region(rd_addr_i);
  assign op_reg = fpp_region(op_addr_i);
  assign rd_re_ok_o = re_i[rd_reg[REGION_W-1:5]][rd_reg[4:0]];
  assign op_pe_ok_o = pe_i[op_reg[REGION_W-1:5]][op_reg[4:0]];

endmodule

// *** test/fpp_array_model.sv ***
// behavioural flash array on the controller's array port
`timescale 1ns/10ps
module fpp_array_model (
  input  wire fpp_pkg::fpp_arr_req_type req_i,
  input  wire logic                     mclk_i,
  output logic [31:0]                   rdata_o
);
  import fpp_pkg::*;
  logic [31:0] mem [logic [31:0]];
  logic        prog_q  = 1'b0;
  logic        erase_q = 1'b0;
  logic        mass_q  = 1'b0;
  // words never written read as erased
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : '1;
  endfunction
  initial rdata_o = '0;
  always @(posedge mclk_i) begin
    prog_q  <= req_i.prog;
    erase_q <= req_i.erase;
    mass_q  <= req_i.mass;
    // idle bus toggles, so stale data never passes for a read
    rdata_o <= req_i.rd ? peek(req_i.addr) : ~rdata_o;
    if (req_i.prog && !prog_q) begin
      mem[req_i.addr] = peek(req_i.addr) & req_i.wdata;
    end
    if (req_i.erase && !erase_q) begin
      foreach (mem[k]) begin
        if (k[31:PAGE_LSB] == req_i.addr[31:PAGE_LSB]) begin
          mem[k] = '1;
        end
      end
    end
    if (req_i.mass && !mass_q) begin
      mem.delete();
    end
  end
endmodule

// *** test/fpp_flash_ctrl_test.sv ***
// self-checking bench of the flash program/protect controller
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module fpp_flash_ctrl_test;
  import fpp_pkg::*;
  localparam fpp_bank_type IMPL = {64'h0, 32'h0000ffff, 32'hffffffff};
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, nv_init_i = 1'b0, mask = 1'b0;
  fpp_wr_type aw = '0, dw = '0, cw = '0, uw = '0;
  fpp_sel_wr_type pw = '0, sw = '0;
  fpp_rd_req_type rq = '0;
  logic [31:0] arr_rdata, ctrl_rd, rd_data, dbg, addr_rd, data_rd;
  logic [7:0] usec_rd;
  fpp_bank_type re_bits, pe_bits;
  logic [1:0][31:0] user_w;
  logic busy, pfault, afault, rfault, rd_rdy, rd_vld;
  fpp_arr_req_type arr_req;
  int errors = 0, cmp_count = 0;

  fpp_flash_ctrl #(.REGIONS(48), .PAGE_ERASE_US(3), .MASS_ERASE_US(5)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .nv_init_i(nv_init_i),
    .addr_wr_i(aw), .data_wr_i(dw), .ctrl_wr_i(cw), .usec_wr_i(uw),
    .prot_wr_i(pw), .user_wr_i(sw), .access_fault_mask_i(mask),
    .rd_req_i(rq), .arr_rdata_i(arr_rdata), .addr_rdata_o(addr_rd),
    .data_rdata_o(data_rd), .ctrl_rdata_o(ctrl_rd), .usec_rdata_o(usec_rd),
    .read_enable_bits_o(re_bits), .program_enable_bits_o(pe_bits),
    .user_words_o(user_w), .debug_config_word_o(dbg), .busy_o(busy),
    .prog_fault_o(pfault), .access_fault_o(afault),
    .read_fault_o(rfault), .rd_ready_o(rd_rdy), .rd_valid_o(rd_vld),
    .rd_data_o(rd_data), .arr_req_o(arr_req));
  fpp_array_model u_arr (.mclk_i(mclk_i), .req_i(arr_req),
    .rdata_o(arr_rdata));

  initial forever #2 mclk_i = ~mclk_i;

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // every task starts and ends 1 ns after a rising edge
  task automatic rst(input logic nv);
    sys_rst_i = 1'b1;
    nv_init_i = nv;
    repeat (2) @(posedge mclk_i);
    #1 sys_rst_i = 1'b0;
    nv_init_i = 1'b0;
  endtask
  task automatic wreg(input int k, input logic [31:0] d);
    case (k)
      0: aw = '{1'b1, d};
      1: dw = '{1'b1, d};
      2: cw = '{1'b1, d};
      default: uw = '{1'b1, d};
    endcase
    @(posedge mclk_i);
    #1;
    case (k)
      0: aw.we = 1'b0;
      1: dw.we = 1'b0;
      2: cw.we = 1'b0;
      default: uw.we = 1'b0;
    endcase
  endtask
  task automatic wsel(input logic u, input logic [2:0] s,
                      input logic [31:0] d);
    if (u) sw = '{1'b1, s, d};
    else pw = '{1'b1, s, d};
    @(posedge mclk_i);
    #1;
    if (u) sw.we = 1'b0;
    else pw.we = 1'b0;
  endtask
  // ok: 1 accepted, 0 refused with fault, 2 silently ignored
  task automatic go(input logic [31:0] a, input int b,
                    input logic [31:0] d, input int ok);
    wreg(1, d);
    wreg(0, a);
    wreg(2, {FLASH_KEY, 16'(1 << b)});
    `CHK(addr_rd, a)
    `CHK(data_rd, d)
    if (ok == 1) begin
      `CHK(ctrl_rd[b], 1'b1)
      `CHK(rd_rdy, b == OP_COMMIT)
      // sample 1 ns after the edge, never in the launching time step
      for (int i = 0; i < 400 && busy !== 1'b0; i++) begin
        @(posedge mclk_i);
        #1;
      end
      `CHK(ctrl_rd, 32'h0)
      `CHK(rd_rdy, 1'b1)
    end else begin
      `CHK(pfault, ok == 0)
      `CHK(afault, (ok == 0) & mask)
      `CHK(busy, 1'b0)
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic f,
                    input logic [31:0] e, input logic flt);
    rq = '{1'b1, f, a};
    @(posedge mclk_i);
    #1 rq.req = 1'b0;
    for (int i = 0; i < 4 && rd_vld !== 1'b1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    `CHK(rd_vld, 1'b1)
    `CHK(rd_data, e)
    `CHK(rfault, flt)
  endtask

  initial begin
    #200000;
    errors++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    rst(1'b1);
    `CHK(usec_rd, RELOAD_DFLT)
    `CHK(re_bits, IMPL)
    `CHK(pe_bits, IMPL)
    wreg(3, 32'h1);
    `CHK(usec_rd, 8'h01)
    $display("test reset done");
    go(32'h100, OP_WRITE, 32'h12345678, 1);
    rd(32'h100, 1'b0, 32'h12345678, 1'b0);
    go(32'h100, OP_WRITE, 32'hff00ff00, 1);
    rd(32'h100, 1'b0, 32'h12005600, 1'b0);
    go(32'h400, OP_WRITE, 32'ha5a5a5a5, 1);
    go(32'h000, OP_ERASE, 32'h0, 1);
    rd(32'h100, 1'b0, 32'hffffffff, 1'b0);
    rd(32'h400, 1'b0, 32'ha5a5a5a5, 1'b0);
    wreg(2, 32'h12340002);
    `CHK(busy, 1'b0)
    rd(32'h400, 1'b0, 32'ha5a5a5a5, 1'b0);
    go(32'h0, OP_MASS, 32'h0, 1);
    rd(32'h400, 1'b0, 32'hffffffff, 1'b0);
    `CHK(user_w[0], USER_FACTORY)
    $display("test program erase done");
    wsel(1'b0, 3'h4, 32'hfffffffe);
    `CHK(pe_bits[0], 32'hfffffffe)
    mask = 1'b1;
    go(32'h400, OP_WRITE, 32'h0, 0);
    rd(32'h400, 1'b0, 32'hffffffff, 1'b0);
    go(32'h000, OP_ERASE, 32'h0, 0);
    mask = 1'b0;
    go(32'h0, OP_MASS, 32'h0, 0);
    go(32'h800, OP_WRITE, 32'h0000ffff, 1);
    wsel(1'b0, 3'h0, 32'hfffffffd);
    rd(32'h800, 1'b0, 32'h0, 1'b1);
    rd(32'h800, 1'b1, 32'h0000ffff, 1'b0);
    $display("test protection done");
    go(32'h1, OP_COMMIT, 32'h0, 1);
    wsel(1'b1, 3'h0, 32'h1fff0000);
    go(CA_USER[0], OP_COMMIT, 32'h0, 1);
    go(CA_DBG, OP_COMMIT, 32'h12345670, 1);
    `CHK(dbg, 32'h12345670)
    go(32'h6, OP_COMMIT, 32'h0, 2);
    rst(1'b0);
    `CHK(usec_rd, RELOAD_DFLT)
    `CHK(pe_bits[0], 32'hfffffffe)
    `CHK(re_bits[0], 32'hffffffff)
    `CHK(user_w[0], 32'h1fff0000)
    wsel(1'b0, 3'h4, 32'hffffffff);
    `CHK(pe_bits[0], 32'hfffffffe)
    wreg(3, 32'h1);
    wsel(1'b1, 3'h0, 32'h0);
    go(CA_USER[0], OP_COMMIT, 32'h0, 2);
    rst(1'b0);
    `CHK(user_w[0], 32'h1fff0000)
    `CHK(dbg, 32'h12345670)
    $display("test commit done");
    close_out();
  end
endmodule
